/* drm_pkg.sv */
// Shared constants for the drum addressing and angular position logic
package drm_pkg;

    localparam int ANGLE_W       = 11;
    localparam int POSITIONS     = 2048;
    localparam int GROUPS        = 12;
    localparam int GROUP_W       = 4;
    localparam int WORD_W        = 16;
    localparam int INTERLACE_W   = 3;

    // Bus digit n sits at bit WORD_W-1-n; digit 0 is the sign
    localparam int GRP_LSB       = 11;
    localparam int POS_LSB       = 0;

    localparam logic [ANGLE_W-1:0] ANGLE_MAX   = 11'h7ff;
    localparam logic [ANGLE_W-1:0] ANGLE_RESET = 11'h000;
    localparam logic [ANGLE_W-1:0] WPC_RESET   = 11'h000;
    localparam logic [GROUP_W-1:0] GRP_RESET   = 4'h0;

    // Relay settling time, counted by the controlling party
    localparam int RELAY_DELAY_MS = 12;
    localparam int CLK_PERIOD_NS  = 40;
    localparam int RELAY_CYCLES   = RELAY_DELAY_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        XS_IDLE,
        XS_HUNT,
        XS_MOVE
    } drm_xfer_state_t;

endpackage : drm_pkg

/* drm_sync.sv */
// Two-stage synchroniser for pins arriving from the drum
`timescale 1ns/1ps
module drm_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    initial begin
        if (W < 1) begin
            $error("drm_sync width must be positive");
        end
    end

    always_comb begin
        meta_nxt = meta_r;
        q_nxt    = q_r;
        if (ce) begin
            meta_nxt = d_in;
            q_nxt    = meta_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : drm_sync

/* drm_addr_pos.sv */
// Drum angle tracking, address selection and single-word transfer control
`timescale 1ns/1ps
module drm_addr_pos
    import drm_pkg::*;
#(
    parameter int NUM_GROUPS = GROUPS
) (
    // Clock, reset, enable
    input  wire logic                  REF_CLK,
    input  wire logic                  RST_B,
    input  wire logic                  CLK_EN,
    // Drum timing and sync track pins
    input  wire logic                  TIMING_PULSE,
    input  wire logic                  SYNC_PULSE,
    // Head polarity pins, one per track of a group
    input  wire logic [WORD_W-1:0]     READ_POL,
    output logic      [WORD_W-1:0]     WRITE_POL,
    output logic                       RECORD_EN,
    output logic      [NUM_GROUPS-1:0] HEAD_GROUP_SEL,
    // Select orders from the computer
    input  wire logic [WORD_W-1:0]     BUS_DIGITS,
    input  wire logic                  CHANGE_GROUP,
    input  wire logic                  CHANGE_POS,
    output logic                       GROUP_CHANGED,
    // Single-word transfer
    input  wire logic                  XFER_REQ,
    input  wire logic                  XFER_RECORD,
    input  wire logic [WORD_W-1:0]     WRITE_DATA,
    output logic                       XFER_BUSY,
    output logic                       XFER_DONE,
    output logic      [WORD_W-1:0]     READ_DATA,
    // Status
    output logic      [ANGLE_W-1:0]    ANGLE_POS,
    output logic      [ANGLE_W-1:0]    WORD_POS,
    output logic      [GROUP_W-1:0]    GROUP_POS,
    output logic                       SYNC_ALARM,
    input  wire logic                  ALARM_CLR
);

    initial begin
        if (NUM_GROUPS < 1 || NUM_GROUPS > (1 << GROUP_W)) begin
            $error("drm_addr_pos group count outside selector range");
        end
        if ((1 << ANGLE_W) != POSITIONS) begin
            $error("drm_addr_pos angle width does not cover one revolution");
        end
        if (GRP_LSB + GROUP_W > WORD_W || POS_LSB + ANGLE_W > GRP_LSB) begin
            $error("drm_addr_pos bus digit fields overlap or overflow");
        end
        if (ANGLE_W <= INTERLACE_W) begin
            $error("drm_addr_pos interlace wider than angle counter");
        end
    end

    // Pin synchronisers; polarity has the pulse's depth so both stay aligned
    logic              tmg_s;
    logic              sync_s;
    logic [WORD_W-1:0] rd_pol_s;

    drm_sync #(
        .W (1)
    ) u_sync_tmg (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .ce    (CLK_EN),
        .d_in  (TIMING_PULSE),
        .q     (tmg_s)
    );

    drm_sync #(
        .W (1)
    ) u_sync_rev (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .ce    (CLK_EN),
        .d_in  (SYNC_PULSE),
        .q     (sync_s)
    );

    drm_sync #(
        .W (WORD_W)
    ) u_sync_pol (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .ce    (CLK_EN),
        .d_in  (READ_POL),
        .q     (rd_pol_s)
    );

    // Angle tracking state
    logic               tmg_d_r;
    logic               tmg_d_nxt;
    logic               sync_d_r;
    logic               sync_d_nxt;
    logic [ANGLE_W-1:0] angle_r;
    logic [ANGLE_W-1:0] angle_nxt;
    logic               carry_r;
    logic               carry_nxt;
    logic               synced_r;
    logic               synced_nxt;
    logic               alarm_r;
    logic               alarm_nxt;
    logic               arrived_r;
    logic               arrived_nxt;
    logic               tick;
    logic               sync_edge;

    assign tick      = tmg_s & ~tmg_d_r;
    assign sync_edge = sync_s & ~sync_d_r;

    always_comb begin
        tmg_d_nxt   = tmg_d_r;
        sync_d_nxt  = sync_d_r;
        angle_nxt   = angle_r;
        carry_nxt   = carry_r;
        synced_nxt  = synced_r;
        alarm_nxt   = alarm_r;
        arrived_nxt = arrived_r;
        if (CLK_EN) begin
            tmg_d_nxt   = tmg_s;
            sync_d_nxt  = sync_s;
            arrived_nxt = tick | sync_edge;
            if (ALARM_CLR) begin
                alarm_nxt = 1'b0;
            end
            if (sync_edge) begin
                angle_nxt  = ANGLE_RESET;
                synced_nxt = 1'b1;
                carry_nxt  = 1'b0;
                // First sync after reset has no carry to check against
                if (synced_r && !carry_r) begin
                    alarm_nxt = 1'b1;
                end
            end else if (tick) begin
                angle_nxt = angle_r + 11'h001;
                carry_nxt = (angle_r == ANGLE_MAX);
                // A pulse slipped in between the carry and the sync
                if (synced_r && carry_r) begin
                    alarm_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            tmg_d_r   <= 1'b0;
            sync_d_r  <= 1'b0;
            angle_r   <= ANGLE_RESET;
            carry_r   <= 1'b0;
            synced_r  <= 1'b0;
            alarm_r   <= 1'b0;
            arrived_r <= 1'b0;
        end else begin
            tmg_d_r   <= tmg_d_nxt;
            sync_d_r  <= sync_d_nxt;
            angle_r   <= angle_nxt;
            carry_r   <= carry_nxt;
            synced_r  <= synced_nxt;
            alarm_r   <= alarm_nxt;
            arrived_r <= arrived_nxt;
        end
    end

    // Address and transfer state
    drm_xfer_state_t    st_r;
    drm_xfer_state_t    st_nxt;
    logic [GROUP_W-1:0] grp_r;
    logic [GROUP_W-1:0] grp_nxt;
    logic [ANGLE_W-1:0] wpc_r;
    logic [ANGLE_W-1:0] wpc_nxt;
    logic               rec_op_r;
    logic               rec_op_nxt;
    logic [WORD_W-1:0]  wdata_r;
    logic [WORD_W-1:0]  wdata_nxt;
    logic [WORD_W-1:0]  rdata_r;
    logic [WORD_W-1:0]  rdata_nxt;
    logic               rec_en_r;
    logic               rec_en_nxt;
    logic               done_r;
    logic               done_nxt;
    logic               gchg_r;
    logic               gchg_nxt;
    logic               grp_valid;
    logic [ANGLE_W-1:0] target_pos;

    // Word n sits at angle (n mod 256)*8 + n/256
    assign target_pos = {wpc_r[ANGLE_W-INTERLACE_W-1:0],
                         wpc_r[ANGLE_W-1 -: INTERLACE_W]};
    assign grp_valid  = ({28'h0000000, grp_r} < NUM_GROUPS);

    always_comb begin
        st_nxt     = st_r;
        grp_nxt    = grp_r;
        wpc_nxt    = wpc_r;
        rec_op_nxt = rec_op_r;
        wdata_nxt  = wdata_r;
        rdata_nxt  = rdata_r;
        rec_en_nxt = rec_en_r;
        done_nxt   = done_r;
        gchg_nxt   = gchg_r;
        if (CLK_EN) begin
            rec_en_nxt = 1'b0;
            done_nxt   = 1'b0;
            gchg_nxt   = 1'b0;
            case (st_r)
                XS_IDLE: begin
                    if (XFER_REQ) begin
                        rec_op_nxt = XFER_RECORD;
                        wdata_nxt  = WRITE_DATA;
                        st_nxt     = XS_HUNT;
                    end
                end
                XS_HUNT: begin
                    // Act once, on the pulse that brings the word under the heads
                    if (arrived_r && angle_r == target_pos) begin
                        st_nxt     = XS_MOVE;
                        rec_en_nxt = rec_op_r & grp_valid;
                        if (!rec_op_r) begin
                            rdata_nxt = grp_valid ? rd_pol_s : '0;
                        end
                    end
                end
                XS_MOVE: begin
                    done_nxt = 1'b1;
                    // Wraps at 2047 with no carry into the group
                    wpc_nxt  = wpc_r + 11'h001;
                    st_nxt   = XS_IDLE;
                end
                default: begin
                    st_nxt = XS_IDLE;
                end
            endcase
            // Load orders override the automatic increment
            if (CHANGE_POS) begin
                wpc_nxt = BUS_DIGITS[POS_LSB +: ANGLE_W];
            end
            if (CHANGE_GROUP) begin
                grp_nxt  = BUS_DIGITS[GRP_LSB +: GROUP_W];
                // Relays always switch, so reads get the delay too
                gchg_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            st_r     <= XS_IDLE;
            grp_r    <= GRP_RESET;
            wpc_r    <= WPC_RESET;
            rec_op_r <= 1'b0;
            wdata_r  <= '0;
            rdata_r  <= '0;
            rec_en_r <= 1'b0;
            done_r   <= 1'b0;
            gchg_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            grp_r    <= grp_nxt;
            wpc_r    <= wpc_nxt;
            rec_op_r <= rec_op_nxt;
            wdata_r  <= wdata_nxt;
            rdata_r  <= rdata_nxt;
            rec_en_r <= rec_en_nxt;
            done_r   <= done_nxt;
            gchg_r   <= gchg_nxt;
        end
    end

    // Head group selection, one relay line per group
    logic [NUM_GROUPS-1:0] hsel_r;
    logic [NUM_GROUPS-1:0] hsel_nxt;

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_head
            // Codes past the last group leave every line low
            assign hsel_nxt[g] = CLK_EN ? (grp_nxt == GROUP_W'(g))
                                        : hsel_r[g];
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            hsel_r <= '0;
        end else begin
            hsel_r <= hsel_nxt;
        end
    end

    // Outputs
    assign WRITE_POL      = wdata_r;
    assign RECORD_EN      = rec_en_r;
    assign HEAD_GROUP_SEL = hsel_r;
    assign GROUP_CHANGED  = gchg_r;
    assign XFER_BUSY      = (st_r != XS_IDLE);
    assign XFER_DONE      = done_r;
    assign READ_DATA      = rdata_r;
    assign ANGLE_POS      = angle_r;
    assign WORD_POS       = wpc_r;
    assign GROUP_POS      = grp_r;
    assign SYNC_ALARM     = alarm_r;

endmodule : drm_addr_pos

/* drm_addr_pos_properties.sv */
// Assertions on the drum angle and addressing ports
`timescale 1ns/1ps
module drm_addr_pos_chk
    import drm_pkg::*;
#(
    parameter int NUM_GROUPS = GROUPS
) (
    // Clock and orders
    input wire logic                  REF_CLK,
    input wire logic                  RST_B,
    input wire logic                  CLK_EN,
    input wire logic [WORD_W-1:0]     BUS_DIGITS,
    input wire logic                  CHANGE_GROUP,
    input wire logic                  CHANGE_POS,
    input wire logic                  ALARM_CLR,
    // Outputs watched
    input wire logic                  GROUP_CHANGED,
    input wire logic                  XFER_BUSY,
    input wire logic                  XFER_DONE,
    input wire logic                  RECORD_EN,
    input wire logic [NUM_GROUPS-1:0] HEAD_GROUP_SEL,
    input wire logic [ANGLE_W-1:0]    ANGLE_POS,
    input wire logic [ANGLE_W-1:0]    WORD_POS,
    input wire logic [GROUP_W-1:0]    GROUP_POS,
    input wire logic                  SYNC_ALARM
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    AST_GROUP_LOAD: assert property (CLK_EN && CHANGE_GROUP |=> GROUP_CHANGED &&
        GROUP_POS == $past(BUS_DIGITS[14:11])) else $error("group load wrong");
    AST_POS_LOAD: assert property (CLK_EN && CHANGE_POS |=>
        WORD_POS == $past(BUS_DIGITS[10:0])) else $error("position load wrong");
    // Held one cycle past reset: the select only settles on the first enabled edge
    AST_HEAD_SEL: assert property ($past(RST_B) && $past(CLK_EN) |->
        HEAD_GROUP_SEL == NUM_GROUPS'(GROUP_POS < NUM_GROUPS) << GROUP_POS)
        else $error("head select wrong");
    AST_MATCH_ANGLE: assert property (RECORD_EN |->
        ANGLE_POS == {WORD_POS[7:0], WORD_POS[10:8]}) else $error("record off angle");
    AST_REC_RANGE: assert property (RECORD_EN |->
        GROUP_POS < NUM_GROUPS && HEAD_GROUP_SEL != '0) else $error("record out of range");
    AST_DONE_STEP: assert property (XFER_DONE && !$past(CHANGE_POS) && !$past(CHANGE_GROUP)
        |-> WORD_POS == $past(WORD_POS) + 11'h1 && $stable(GROUP_POS)) else $error("step wrong");
    AST_DONE_BUSY: assert property (XFER_DONE |-> !XFER_BUSY && $past(XFER_BUSY, 2))
        else $error("done without hunt");
    AST_ALARM_STICKY: assert property (SYNC_ALARM && !ALARM_CLR |=> SYNC_ALARM)
        else $error("alarm dropped");
endmodule : drm_addr_pos_chk

bind drm_addr_pos drm_addr_pos_chk #(.NUM_GROUPS(NUM_GROUPS)) u_chk (.REF_CLK, .RST_B, .CLK_EN,
    .BUS_DIGITS, .CHANGE_GROUP, .CHANGE_POS, .ALARM_CLR, .GROUP_CHANGED, .XFER_BUSY, .XFER_DONE,
    .RECORD_EN, .HEAD_GROUP_SEL, .ANGLE_POS, .WORD_POS, .GROUP_POS, .SYNC_ALARM);

/* drm_ioc_model.sv */
// In-out control model: select orders, single-word transfers, relay wait
`timescale 1ns/1ps
module drm_ioc_model
    import drm_pkg::*;
#(
    parameter int RELAY_CYC = 24
) (
    // Clock and answer
    input  wire logic              clk,
    input  wire logic              group_changed,
    // Orders
    output logic      [WORD_W-1:0] bus_digits,
    output logic                   change_group,
    output logic                   change_pos,
    output logic                   xfer_req,
    output logic                   xfer_record,
    output logic      [WORD_W-1:0] write_data
);
    // Relay wait scaled down so runs stay short
    int relay_left = 0;
    initial {bus_digits, change_group, change_pos, xfer_req, xfer_record, write_data} = '0;
    always @(posedge clk) relay_left <= group_changed ? RELAY_CYC : relay_left - (relay_left > 0);

    task automatic select(input logic [3:0] g, input logic [10:0] p, input logic cg, cp);
        bus_digits = {1'b0, g, p};
        change_group = cg;
        change_pos = cp;
        @(posedge clk);
        #1;
        change_group = 1'b0;
        change_pos = 1'b0;
    endtask : select

    task automatic xfer(input logic rec, input logic [WORD_W-1:0] d);
        // Reads wait as well: the relays switch on every group change
        do begin @(posedge clk); #1; end while (relay_left != 0);
        xfer_record = rec;
        write_data = d;
        xfer_req = 1'b1;
        @(posedge clk);
        #1;
        xfer_req = 1'b0;
    endtask : xfer
endmodule : drm_ioc_model

/* drm_addr_pos_tb.sv */
// Self-checking bench for the drum angle and addressing block
`timescale 1ns/1ps
module drm_addr_pos_tb;
    import drm_pkg::*;
    typedef struct {
        logic rec, ok;
        logic [WORD_W-1:0] d;
        logic [ANGLE_W-1:0] wp, a;
        logic [GROUP_W-1:0] g;
    } drm_exp_t;
    logic               REF_CLK = 0, RST_B = 0, CLK_EN = 1, ALARM_CLR = 0;
    logic               TIMING_PULSE = 0, SYNC_PULSE = 0, bad_sync = 0, rec_seen = 0;
    logic               CHANGE_GROUP, CHANGE_POS, XFER_REQ, XFER_RECORD, GROUP_CHANGED;
    logic               XFER_BUSY, XFER_DONE, RECORD_EN, SYNC_ALARM;
    logic [WORD_W-1:0]  READ_POL = '0, BUS_DIGITS, WRITE_DATA, WRITE_POL, READ_DATA;
    logic [GROUPS-1:0]  HEAD_GROUP_SEL;
    logic [GROUP_W-1:0] GROUP_POS;
    logic [ANGLE_W-1:0] ANGLE_POS, WORD_POS, next_w = '0, drum = 11'h7ff, a_hold;
    int                 failures = 0, comparisons = 0, dones = 0, issued = 0, seed = 62;
    drm_exp_t           q[$];

    drm_addr_pos dut (.REF_CLK, .RST_B, .CLK_EN, .TIMING_PULSE, .SYNC_PULSE, .READ_POL,
        .WRITE_POL, .RECORD_EN, .HEAD_GROUP_SEL, .BUS_DIGITS, .CHANGE_GROUP, .CHANGE_POS,
        .GROUP_CHANGED, .XFER_REQ, .XFER_RECORD, .WRITE_DATA, .XFER_BUSY, .XFER_DONE,
        .READ_DATA, .ANGLE_POS, .WORD_POS, .GROUP_POS, .SYNC_ALARM, .ALARM_CLR);
    drm_ioc_model ioc (.clk(REF_CLK), .group_changed(GROUP_CHANGED), .bus_digits(BUS_DIGITS),
        .change_group(CHANGE_GROUP), .change_pos(CHANGE_POS), .xfer_req(XFER_REQ),
        .xfer_record(XFER_RECORD), .write_data(WRITE_DATA));

    initial forever #20 REF_CLK = ~REF_CLK;

    task automatic tick(input int n);
        repeat (n) begin @(posedge REF_CLK); #1; end
    endtask : tick

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [WORD_W-1:0] pat(input logic [ANGLE_W-1:0] a);
        return {a[4:0], a} ^ 16'h5a5a;
    endfunction : pat

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic run(input logic rec, sel, input logic [3:0] g, input logic [10:0] p);
        drm_exp_t e;
        logic [ANGLE_W-1:0] w;
        w = sel ? p : next_w;
        next_w = w + 11'h1;
        e.rec = rec;
        e.ok = g < GROUPS;
        e.a = {w[7:0], w[10:8]};
        e.d = rec ? 16'($random(seed)) : (e.ok ? pat(e.a) : 16'h0);
        e.wp = next_w;
        e.g = g;
        q.push_back(e);
        if (sel) ioc.select(g, p, 1'b1, 1'b1);
        ioc.xfer(rec, e.d);
        chk("XFER_BUSY", 16'h1, 16'(XFER_BUSY));
        issued++;
        for (int i = 0; i < 13000 && dones != issued; i++) tick(1);
        if (dones != issued) begin
            failures++;
            $display("MISMATCH XFER_DONE expected %0d seen %0d", issued, dones);
            print_verdict();
        end
    endtask : run

    // Drum tracks: six-cycle slots, sync just after the timing pulse of the wrap slot
    initial begin
        @(posedge RST_B);
        forever begin
            drum = drum + 11'h1;
            READ_POL = pat(drum);
            TIMING_PULSE = 1'b1;
            tick(2);
            TIMING_PULSE = 1'b0;
            SYNC_PULSE = (drum == 11'h0) || bad_sync;
            bad_sync = 1'b0;
            tick(2);
            SYNC_PULSE = 1'b0;
            tick(2);
        end
    end

    always @(negedge REF_CLK) begin
        if (RECORD_EN) begin
            rec_seen = 1'b1;
            chk("WRITE_POL", q[0].d, WRITE_POL);
        end
        if (XFER_DONE) begin
            chk("RECORD_EN", 16'(q[0].rec && q[0].ok), 16'(rec_seen));
            if (!q[0].rec) chk("READ_DATA", q[0].d, READ_DATA);
            chk("WORD_POS", 16'(q[0].wp), 16'(WORD_POS));
            chk("ANGLE_POS", 16'(q[0].a), 16'(ANGLE_POS));
            chk("GROUP_POS", 16'(q[0].g), 16'(GROUP_POS));
            void'(q.pop_front());
            rec_seen = 1'b0;
            dones++;
        end
    end

    initial begin
        tick(6);
        RST_B = 1'b1;
        chk("WORD_POS", 16'h0, 16'(WORD_POS));
        chk("SYNC_ALARM", 16'h0, 16'(SYNC_ALARM));
        $display("test reset done");
        for (int g = 0; g < 16; g++) begin
            ioc.select(4'(g), 11'h0, 1'b1, 1'b0);
            chk("HEAD_GROUP_SEL", (g < GROUPS) ? 16'h1 << g : 16'h0, 16'(HEAD_GROUP_SEL));
            chk("GROUP_CHANGED", 16'h1, 16'(GROUP_CHANGED));
            tick(1);
        end
        run(1'b1, 1'b1, 4'h3, 11'h7ff);
        run(1'b0, 1'b0, 4'h3, 11'h0);
        run(1'b0, 1'b0, 4'h3, 11'h0);
        run(1'b0, 1'b1, 4'hb, 11'($random(seed)));
        run(1'b0, 1'b1, 4'hd, 11'($random(seed)));
        run(1'b1, 1'b1, 4'he, 11'($random(seed)));
        $display("test transfers done");
        chk("SYNC_ALARM", 16'h0, 16'(SYNC_ALARM));
        bad_sync = 1'b1;
        for (int i = 0; i < 40 && SYNC_ALARM !== 1'b1; i++) tick(1);
        chk("SYNC_ALARM", 16'h1, 16'(SYNC_ALARM));
        ALARM_CLR = 1'b1;
        tick(1);
        ALARM_CLR = 1'b0;
        tick(1);
        chk("SYNC_ALARM", 16'h0, 16'(SYNC_ALARM));
        $display("test alarm done");
        CLK_EN = 1'b0;
        a_hold = ANGLE_POS;
        ioc.select(4'h5, 11'h123, 1'b1, 1'b1);
        tick(12);
        chk("ANGLE_POS", 16'(a_hold), 16'(ANGLE_POS));
        chk("GROUP_POS", 16'he, 16'(GROUP_POS));
        chk("WORD_POS", 16'(next_w), 16'(WORD_POS));
        $display("test freeze done");
        print_verdict();
    end
endmodule : drm_addr_pos_tb
